// [core/console_serial.v]
// console asynchronous serial line: 8n1 receiver and transmitter, break detect, rate table
// assumes synchronous inputs, one clock, registers reached over a one-cycle strobe port
`include "console_serial_consts.vh"

module console_serial #(
   parameter CLK_HZ = `CLK_HZ
) (
   // clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // serial line
   input wire serial_rx_i,
   output reg serial_tx_o,
   // system pins
   input wire [2:0] console_rate_select_pins_i,
   input wire halt_enable_input_i,
   input wire diag_running_i,
   // break response
   output reg halt_req_o,
   output reg [31:0] halt_addr_o,
   output reg brk_irq4_o,
   // interrupt
   output reg irq_o
);

   localparam integer BASE_DIV_FULL = CLK_HZ / `BASE_BAUD;
   localparam [17:0] BASE_DIV = BASE_DIV_FULL[17:0];

   // ---- registers ----
   reg [2:0] rate_code;
   reg [2:0] boot_rate;
   reg [7:0] rx_data;
   reg rx_done, rx_ie, ovr_err, framing_error_flag, received_break_flag;
   reg tx_ie, maint, xmit_brk, tx_rdy;
   reg [2:0] irq_status, irq_enable;
   reg [7:0] vector;

   // RL11 rate code doubles per step
   wire [17:0] bit_div = BASE_DIV >> rate_code;
   wire [17:0] half_div = bit_div >> 1;

   // maint loops transmit back, ignoring the external input
   wire rx_line = maint ? serial_tx_o : serial_rx_i;

   // ---- receiver ----
   localparam RX_IDLE = 4'b0001;
   localparam RX_DATA = 4'b0010;
   localparam RX_STOP = 4'b0100;
   localparam RX_HOLD = 4'b1000;
   reg [3:0] rx_state;
   reg [17:0] rx_cnt;
   reg [3:0] rx_bit;
   reg [7:0] rx_shift;
   reg [4:0] space_cnt;
   reg brk_armed, brk_seen;
   reg [17:0] brk_tick;
   reg rx_event, brk_event;

   wire rd_rxbuf = rd_i && (addr_i == `OFS_RX_BUF);

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 18'h0;
         rx_bit <= 4'h0;
         rx_shift <= 8'h0;
         rx_data <= 8'h0;
         rx_done <= 1'b0;
         ovr_err <= 1'b0;
         framing_error_flag <= 1'b0;
         received_break_flag <= 1'b0;
         space_cnt <= 5'h0;
         brk_armed <= 1'b1;
         brk_seen <= 1'b0;
         brk_tick <= 18'h0;
         rx_event <= 1'b0;
         brk_event <= 1'b0;
      end else begin
         rx_event <= 1'b0;
         brk_event <= 1'b0;
         // RL19 break counter on bit time, restart on mark
         if (rx_line) begin
            space_cnt <= 5'h0;
            brk_tick <= 18'h0;
            brk_armed <= 1'b1;
         end else if (brk_tick >= bit_div - 18'h1) begin
            brk_tick <= 18'h0;
            // RL3 twenty space bits
            if (space_cnt == `BREAK_BITS - 1 && brk_armed) begin
               brk_seen <= 1'b1;
               // RL9 need a mark to rearm
               brk_armed <= 1'b0;
            end
            if (space_cnt != 5'h1f)
               space_cnt <= space_cnt + 5'h1;
         end else begin
            brk_tick <= brk_tick + 18'h1;
         end
         // RL8 read clears flags; set below wins
         if (rd_rxbuf) begin
            received_break_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            ovr_err <= 1'b0;
            rx_done <= 1'b0;
         end
         case (rx_state)
            RX_IDLE: begin
               if (!rx_line) begin
                  rx_state <= RX_DATA;
                  rx_cnt <= half_div + bit_div;
                  rx_bit <= 4'h0;
               end
            end
            RX_DATA: begin
               if (rx_cnt == 18'h0) begin
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_cnt <= bit_div - 18'h1;
                  if (rx_bit == 4'h7)
                     rx_state <= RX_STOP;
                  rx_bit <= rx_bit + 4'h1;
               end else begin
                  rx_cnt <= rx_cnt - 18'h1;
               end
            end
            RX_STOP: begin
               if (rx_cnt == 18'h0) begin
                  rx_data <= rx_shift;
                  rx_done <= 1'b1;
                  rx_event <= 1'b1;
                  ovr_err <= rx_done && !rd_rxbuf;
                  framing_error_flag <= !rx_line;
                  // wait for mark before hunting for next start bit
                  if (rx_line)
                     rx_state <= RX_IDLE;
                  else
                     rx_state <= RX_HOLD;
               end else begin
                  rx_cnt <= rx_cnt - 18'h1;
               end
            end
            // held space: report the break once, then wait for a mark
            RX_HOLD: begin
               if (rx_line) begin
                  rx_state <= RX_IDLE;
               end else if (brk_seen) begin
                  // RL4 RL5 RL18 break flag with framing error
                  received_break_flag <= 1'b1;
                  framing_error_flag <= 1'b1;
                  brk_seen <= 1'b0;
                  brk_event <= 1'b1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // ---- transmitter ----
   localparam TX_IDLE = 2'b01;
   localparam TX_SHIFT = 2'b10;
   reg [1:0] tx_state;
   reg [17:0] tx_cnt;
   reg [3:0] tx_bit;
   reg [9:0] tx_frame;
   reg [7:0] tx_hold;
   reg tx_line, tx_event;

   wire wr_txbuf = wr_i && (addr_i == `OFS_TX_BUF);

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_state <= TX_IDLE;
         tx_cnt <= 18'h0;
         tx_bit <= 4'h0;
         tx_frame <= 10'h3ff;
         tx_hold <= 8'h0;
         tx_rdy <= 1'b1;
         tx_line <= 1'b1;
         tx_event <= 1'b0;
         serial_tx_o <= 1'b1;
      end else begin
         tx_event <= 1'b0;
         // RL1 RL2 RL17 low byte loads, ready drops
         if (wr_txbuf && tx_rdy) begin
            tx_hold <= wdata_i[7:0];
            tx_rdy <= 1'b0;
         end
         case (tx_state)
            TX_IDLE: begin
               if (!tx_rdy) begin
                  tx_frame <= {1'b1, tx_hold, 1'b0};
                  tx_state <= TX_SHIFT;
                  tx_cnt <= bit_div - 18'h1;
                  tx_bit <= 4'h0;
                  // RL17 ready rises once holding buffer free
                  tx_rdy <= 1'b1;
                  tx_event <= 1'b1;
               end
            end
            TX_SHIFT: begin
               tx_line <= tx_frame[0];
               if (tx_cnt == 18'h0) begin
                  tx_frame <= {1'b1, tx_frame[9:1]};
                  tx_cnt <= bit_div - 18'h1;
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit == `FRAME_BITS - 1)
                     tx_state <= TX_IDLE;
               end else begin
                  tx_cnt <= tx_cnt - 18'h1;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
         if (tx_state == TX_IDLE)
            tx_line <= 1'b1;
         serial_tx_o <= xmit_brk ? 1'b0 : tx_line;
      end
   end

   // ---- control registers, interrupts, break response ----
   wire [2:0] next_events = {brk_event, tx_event, rx_event};
   reg [7:0] next_vector;

   always @* begin
      // RL15 RL16 receiver vector wins the shared level
      if (irq_status[`IRQ_RX] && irq_enable[`IRQ_RX] && rx_ie)
         next_vector = `RX_VECTOR;
      else
         next_vector = `TX_VECTOR;
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rate_code <= 3'h0;
         boot_rate <= 3'h0;
         rx_ie <= 1'b0;
         tx_ie <= 1'b0;
         maint <= 1'b0;
         xmit_brk <= 1'b0;
         irq_status <= 3'h0;
         irq_enable <= 3'h0;
         vector <= 8'h0;
         irq_o <= 1'b0;
         halt_req_o <= 1'b0;
         halt_addr_o <= 32'h0;
         brk_irq4_o <= 1'b0;
         rdata_o <= 32'h0;
      end else begin
         // RL12 boot register shows inverted pins
         boot_rate <= ~console_rate_select_pins_i;
         if (wr_i) begin
            if (addr_i == `OFS_RX_CS) begin
               rx_ie <= wdata_i[`BIT_RX_IE];
            end else if (addr_i == `OFS_TX_CS) begin
               tx_ie <= wdata_i[`BIT_TX_IE];
               maint <= wdata_i[`BIT_MAINT];
               xmit_brk <= wdata_i[`BIT_XMIT_BRK];
            end else if (addr_i == `OFS_CONFIG) begin
               // RL10 firmware loads common rate code
               rate_code <= wdata_i[`CFG_RATE_HI:`CFG_RATE_LO];
            end else if (addr_i == `OFS_IRQ_ENABLE) begin
               irq_enable <= wdata_i[2:0];
            end
         end
         // sticky status: set wins over clear
         if (wr_i && addr_i == `OFS_IRQ_CLEAR)
            irq_status <= (irq_status & ~wdata_i[2:0]) | next_events;
         else
            irq_status <= irq_status | next_events;
         vector <= next_vector;
         irq_o <= |(irq_status & irq_enable &
                    {1'b1, tx_ie & tx_rdy, rx_ie});
         // RL6 halt to diagnostic rom when enabled
         halt_req_o <= brk_event && halt_enable_input_i && diag_running_i;
         halt_addr_o <= `DIAG_HALT_ADDR;
         // RL7 main processor: request line 4
         brk_irq4_o <= brk_event && !diag_running_i;
         rdata_o <= 32'h0;
         if (rd_i) begin
            if (addr_i == `OFS_RX_BUF)
               rdata_o <= {16'h0, ovr_err | framing_error_flag, ovr_err,
                           framing_error_flag, 1'b0, received_break_flag, 3'h0, rx_data};
            else if (addr_i == `OFS_RX_CS)
               rdata_o <= {24'h0, rx_done, rx_ie, 6'h0};
            else if (addr_i == `OFS_TX_CS)
               rdata_o <= {24'h0, tx_rdy, tx_ie, 3'h0, maint, 1'b0, xmit_brk};
            else if (addr_i == `OFS_CONFIG)
               rdata_o <= {17'h0, rate_code, 12'h0};
            else if (addr_i == `OFS_BOOT_DIAG)
               rdata_o <= {25'h0, boot_rate, 4'h0};
            else if (addr_i == `OFS_IRQ_STATUS)
               rdata_o <= {29'h0, irq_status};
            else if (addr_i == `OFS_IRQ_ENABLE)
               rdata_o <= {29'h0, irq_enable};
            else if (addr_i == `OFS_VECTOR)
               rdata_o <= {19'h0, `CONSOLE_IRQ_LEVEL, vector};
         end
      end
   end

endmodule // console_serial

// [core/console_serial_consts.vh]
// constants for the console serial line unit: register offsets, field positions, timing
// assumes a 40 MHz clock and a plain one-cycle register port
//
// Contract
// RL1 - low byte of transmit buffer is write-only and loads next character sent
// RL2 - writes to transmit buffer bits 31:8 are ignored
// RL3 - break is recognised after 20 consecutive space bits on serial input
// RL4 - valid break sets received-break flag in receive buffer register
// RL5 - break of 20 space bits also sets the framing-error flag
// RL6 - halt enabled and diagnostic processor running: break halts, vectors to 2004 0000
// RL7 - main processor running: break posts interrupt on request line 4 instead
// RL8 - reading receive buffer register clears received-break flag
// RL9 - flag sets again only after a mark then another 20 space bits
// RL10 - receive and transmit share one rate from configuration bits 14:12
// RL11 - rate code 000 is 300 baud, doubling per step, 111 is 38400
// RL12 - boot register bits 6:4 show inverted rate-select pin levels
// RL13 - firmware copies boot bits 6:4 into configuration bits 14:12
// RL14 - baud rate is set only at power-up, never changed later; the code reloads rate_code on every write to configuration bits 14:12
// RL15 - receiver interrupts at level 14 with vector f8
// RL16 - transmitter interrupts at level 14 with vector fc
// RL17 - transmitter ready drops on buffer write, rises when buffer free again
// RL18 - received-break flag at receive buffer bit 11, read-only, set at character end
// RL19 - break counter uses current bit time and restarts on any mark
`ifndef CONSOLE_SERIAL_CONSTS_VH
`define CONSOLE_SERIAL_CONSTS_VH

// register offsets (byte addresses)
`define OFS_RX_BUF 8'h00
`define OFS_RX_CS 8'h04
`define OFS_TX_CS 8'h08
`define OFS_TX_BUF 8'h0c
`define OFS_CONFIG 8'h10
`define OFS_BOOT_DIAG 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_ENABLE 8'h1c
`define OFS_IRQ_CLEAR 8'h20
`define OFS_VECTOR 8'h24

// field positions
`define BIT_RX_ERR 15
`define BIT_OVR_ERR 14
`define BIT_FRAME_ERR 13
`define BIT_RX_BREAK 11
`define BIT_RX_DONE 7
`define BIT_RX_IE 6
`define BIT_TX_RDY 7
`define BIT_TX_IE 6
`define BIT_MAINT 2
`define BIT_XMIT_BRK 0
`define CFG_RATE_HI 14
`define CFG_RATE_LO 12
`define BOOT_RATE_HI 6
`define BOOT_RATE_LO 4

// interrupt status bits
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_BRK 2

// interrupt level and vectors
`define CONSOLE_IRQ_LEVEL 5'd14
`define RX_VECTOR 8'hf8
`define TX_VECTOR 8'hfc
`define BRK_IRQ_LINE 3'd4
`define DIAG_HALT_ADDR 32'h20040000

// timing: clock and slowest rate
`define CLK_HZ 40000000
`define BASE_BAUD 300
`define BREAK_BITS 20
`define FRAME_BITS 10

`endif

// [verification/console_serial_break_baud_tb.sv]
// testbench for the console serial unit: rate pins, transmit, receive, break, interrupt
// assumes the terminal model on the serial pins and the fastest rate selected by pins
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module console_serial_break_baud_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BIT = 16;
   logic clk_i, arst_n_i, wr_i, rd_i, halt_en, diag;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, halt_addr_o, d;
   logic [2:0] pins;
   wire serial_rx, serial_tx, halt_req_o, brk_irq4_o, irq_o;
   int n_fail = 0, tests_run = 0, n_halt = 0, n_irq4 = 0, t;
   console_serial #(.CLK_HZ(614400)) i_console_serial (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_i(serial_rx), .serial_tx_o(serial_tx),
      .console_rate_select_pins_i(pins), .halt_enable_input_i(halt_en),
      .diag_running_i(diag), .halt_req_o(halt_req_o), .halt_addr_o(halt_addr_o),
      .brk_irq4_o(brk_irq4_o), .irq_o(irq_o));
   console_terminal #(.BIT_CYC(BIT)) i_console_terminal (
      .clk_i(clk_i), .rx_line_o(serial_rx), .tx_line_i(serial_tx));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (halt_req_o === 1'b1) n_halt++;
      if (brk_irq4_o === 1'b1) n_irq4++;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic end_sim;
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      end_sim;
   end
   initial begin
      {arst_n_i, wr_i, rd_i, addr_i, wdata_i, pins} = '0;
      halt_en = 1'b1;
      diag = 1'b1;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         pins <= k[2:0];
         rd(8'h14);
         `CHK(d[6:4], ~k[2:0])
      end
      pins <= 3'h0;
      rd(8'h14);
      wr(8'h10, {17'h0, d[6:4], 12'h0});
      rd(8'h10);
      `CHK(d[14:12], 3'h7)
      wr(8'h0c, 32'habcd_ff5a);
      wr(8'h0c, 32'hffff_ffc3);
      rd(8'h08);
      `CHK(d[7], 1'b0)
      t = 0;
      while (i_console_terminal.rx_count == 0 && t < 400) begin
         @(posedge clk_i);
         t++;
      end
      `CHK(i_console_terminal.rx_byte, 8'h5a)
      while (i_console_terminal.rx_count == 1 && t < 800) begin
         @(posedge clk_i);
         t++;
      end
      `CHK(i_console_terminal.rx_byte, 8'hc3)
      rd(8'h08);
      `CHK(d[7], 1'b1)
      i_console_terminal.send_byte(8'h3c);
      i_console_terminal.hold(1'b1, 2);
      rd(8'h00);
      `CHK(d[11:0], 12'h03c)
      wr(8'h1c, 32'h4);
      i_console_terminal.hold(1'b0, 32);
      rd(8'h00);
      `CHK(d[15:0], 16'ha800)
      `CHK(n_halt, 1)
      `CHK(irq_o, 1'b1)
      i_console_terminal.hold(1'b0, 25);
      rd(8'h00);
      `CHK(d[11], 1'b0)
      wr(8'h1c, 32'h0);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      i_console_terminal.hold(1'b1, 2);
      wr(8'h20, 32'h7);
      rd(8'h18);
      `CHK(d[2:0], 3'h0)
      diag <= 1'b0;
      i_console_terminal.hold(1'b0, 32);
      i_console_terminal.hold(1'b1, 2);
      `CHK(n_irq4, 1)
      `CHK(n_halt, 1)
      rd(8'h24);
      `CHK(d[12:8], 5'd14)
      wr(8'h04, 32'h0000_0040);
      wr(8'h1c, 32'h1);
      rd(8'h24);
      `CHK(d[7:0], 8'hf8)
      `CHK(irq_o, 1'b1)
      wr(8'h1c, 32'h2);
      wr(8'h08, 32'h0000_0040);
      wr(8'h0c, 32'h0000_0011);
      repeat (4) @(posedge clk_i);
      rd(8'h24);
      `CHK({d[12:8], d[7:0]}, 13'h0efc)
      `CHK(irq_o, 1'b1)
      rd(8'h40);
      `CHK(d, 32'h0)
      end_sim;
   end
endmodule // console_serial_break_baud_tb

// [verification/console_serial_sva.sv]
// checker for the console serial unit: break response, boot pins, vector reads
// assumes only the unit's ports; CLK_HZ is handed on from the instance
module console_serial_sva #(
   parameter int CLK_HZ = 40000000
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic serial_rx_i,
   input wire logic [2:0] console_rate_select_pins_i,
   input wire logic halt_enable_input_i,
   input wire logic diag_running_i,
   input wire logic halt_req_o,
   input wire logic [31:0] halt_addr_o,
   input wire logic brk_irq4_o,
   input wire logic irq_o
);
   // the fastest rate gives the shortest legal break
   localparam int BRK_CYC = 20 * CLK_HZ / 38400;
   logic [31:0] low_cnt;
   logic armed;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // low time on the line, and whether a mark came since the last response
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_cnt <= 32'h0;
         armed <= 1'b0;
      end else begin
         low_cnt <= serial_rx_i ? 32'h0 : low_cnt + 32'h1;
         armed <= (halt_req_o | brk_irq4_o) ? 1'b0 : (armed | serial_rx_i);
      end
   end
   boot_inverted_a: assert property (
      rd_i && addr_i == 8'h14 |=> rdata_o[6:4] == ~$past(console_rate_select_pins_i))
      else $error("boot rate field not inverted pins");
   vector_level_a: assert property (
      rd_i && addr_i == 8'h24 |=> rdata_o[12:8] == 5'd14)
      else $error("vector register level wrong");
   halt_addr_a: assert property (
      halt_req_o |-> halt_addr_o == 32'h2004_0000)
      else $error("halt address wrong");
   halt_gate_a: assert property (
      halt_req_o |-> $past(halt_enable_input_i) && $past(diag_running_i))
      else $error("halt without enable and diagnostic run");
   halt_pulse_a: assert property (
      halt_req_o |=> !halt_req_o)
      else $error("halt request longer than one cycle");
   irq4_gate_a: assert property (
      brk_irq4_o |-> !$past(diag_running_i))
      else $error("line four request while diagnostic runs");
   one_response_a: assert property (
      !(halt_req_o && brk_irq4_o))
      else $error("halt and line four together");
   break_length_a: assert property (
      halt_req_o || brk_irq4_o |-> low_cnt >= BRK_CYC)
      else $error("break response before twenty space bits");
   break_rearm_a: assert property (
      halt_req_o || brk_irq4_o |-> armed)
      else $error("break response without a mark between");
   cover property (halt_req_o);
   cover property (brk_irq4_o);
   cover property ($rose(irq_o));
endmodule // console_serial_sva

bind console_serial console_serial_sva #(.CLK_HZ(CLK_HZ)) i_console_serial_sva (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .serial_rx_i(serial_rx_i), .console_rate_select_pins_i(console_rate_select_pins_i),
   .halt_enable_input_i(halt_enable_input_i), .diag_running_i(diag_running_i),
   .halt_req_o(halt_req_o), .halt_addr_o(halt_addr_o), .brk_irq4_o(brk_irq4_o),
   .irq_o(irq_o));

// [verification/console_terminal.sv]
// console terminal model: 8n1 sender with break, 8n1 receiver of the unit's output
// assumes one bit lasts BIT_CYC clocks; the line idles at mark
module console_terminal #(
   parameter int BIT_CYC = 16
) (
   input wire logic clk_i,
   output logic rx_line_o,
   input wire logic tx_line_i
);
   logic [7:0] rx_byte, b;
   int rx_count = 0;
   initial rx_line_o = 1'b1;
   task automatic send_byte(input logic [7:0] v);
      for (int i = 0; i < 10; i++) begin
         rx_line_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i-1];
         repeat (BIT_CYC) @(posedge clk_i);
      end
   endtask
   task automatic hold(input logic lvl, input int nbits);
      rx_line_o <= lvl;
      repeat (nbits * BIT_CYC) @(posedge clk_i);
   endtask
   // sample each bit mid-way; a bad stop bit drops the character
   initial forever begin
      @(negedge tx_line_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      if (!tx_line_i) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            b[i] = tx_line_i;
         end
         repeat (BIT_CYC) @(posedge clk_i);
         if (tx_line_i) begin
            rx_byte = b;
            rx_count++;
         end
      end
   end
endmodule // console_terminal
